// [rss_pkg.sv]
// constants, register map and state codes for reset sequencing and strap sampling
// assumes a 100 MHz core clock and an apb register port with 32-bit data
// Behaviour
// - reset aborts activity; restart at boot vector
// - reset pin synchronised before use
// - first fetch 6.5 clock periods after release
// - strap high: address disable bits steer bus
// - strap low: bus always carries address
// - address strap sampled one clock after release
// - address strap pin floats in hold, float
// - half-clock strap low: divide by two, pll off
// - half-clock strap latched at reset release
// - half-clock pin later general input with pullup
// - both float straps low: float mode
// - float mode floats every pin until reset
// - float strap 1 pullup in reset; drives in hold
// - upper select window defaults to top 64 KB
// - upper-zero pin low at release: clock test
// - timer outputs float in reset and hold
// - dma status output floats in reset, hold
// - address strap low: shared pins normal function
package rss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_US = 1000;
  localparam int RESET_MIN_CYC = RESET_MIN_US * 1000 / CLK_PERIOD_NS;
  localparam int CLK_STABLE_PERIODS = 4;
  // 6.5 processor clock periods, counted in half periods
  localparam int FETCH_HALF_PERIODS = 13;
  localparam int FETCH_CYC_DIV1 = (FETCH_HALF_PERIODS + 1) / 2;
  localparam int FETCH_CYC_DIV2 = FETCH_HALF_PERIODS;
  localparam logic [19:0] BOOT_VECTOR = 20'hFFFF0;
  localparam logic [3:0] UMEM_BASE_RST = 4'hF;
  localparam logic [3:0] UMEM_TOP_NIB = 4'hF;
  localparam logic [7:0] OFS_UMEM_CFG = 8'h00;
  localparam logic [7:0] OFS_LMEM_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int DA_BIT = 0;
  localparam int UMEM_BASE_LSB = 4;
  localparam int ST_ADDR_ENABLE_STRAP_BIT = 0;
  localparam int ST_DIV2_BIT = 1;
  localparam int ST_FLOAT_BIT = 2;
  localparam int ST_CLKTEST_BIT = 3;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_SHORT_BIT = 5;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_WAIT = 2'b10,
    ST_RUN = 2'b11
  } rss_state_e;
endpackage

// [rss_sync3.sv]
// three-stage synchroniser for pins from outside the core clock domain
// assumes the pin may change at any time; output moves when stages 2 and 3 agree
`timescale 1ns/1ns
`default_nettype none
module rss_sync3 #(
  parameter logic INIT = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // filtered level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= INIT;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

  sync_agree_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s2 == s3) |=> (level == $past(s3)))
    else $error("synchroniser output ignores agreed stages");
endmodule
`default_nettype wire

// [rss_strap_hold.sv]
// capture register for sampled strap levels
// assumes capture is a one-cycle pulse on the core clock
`timescale 1ns/1ns
`default_nettype none
module rss_strap_hold #(
  parameter logic INIT = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic capture,
  input wire logic strapIn,
  output logic held
);
  // value kept until the next release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      held <= INIT;
    end else if (capture) begin
      held <= strapIn;
    end
  end

  strap_stable_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !capture |=> $stable(held))
    else $error("strap value changed without capture");
endmodule
`default_nettype wire

// [rss_top.sv]
// reset sequencer, strap sampling, pin float control and apb status registers
// assumes strap and reset pins are asynchronous; bus hold and bus cycle inputs are on core_clk
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rss_top #(
  parameter int RESET_MIN_CYCLES = rss_pkg::RESET_MIN_CYC,
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic resetInLow_b,
  input wire logic addrEnableStrap,
  input wire logic halfClockStrap,
  input wire logic floatTestStrap0,
  input wire logic floatTestStrap1,
  input wire logic upperZeroFlag,
  input wire logic busHold,
  input wire logic cycleStart,
  input wire logic [19:0] cycleAddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic coreReset,
  output logic fetchStart,
  output logic [19:0] fetchAddr,
  output logic upperMemSelect_b,
  output logic addrOnMuxUpper,
  output logic addrOnMuxLower,
  output logic clkDivBy2,
  output logic pllEnable,
  output logic clockTestMode,
  output logic allPinsFloat,
  output logic refresh2Oe_b,
  output logic dmaStatusOe_b,
  output logic timer0Oe_b,
  output logic timer1Oe_b,
  output logic upperZeroOe_b,
  output logic upperSelectOe_b,
  output logic halfClockPullupEn,
  output logic floatStrap1PullupEn,
  output logic generalIoMode
);
  import rss_pkg::*;

  localparam int CNT_W = $clog2(RESET_MIN_CYCLES + 1);
  localparam int fetchCycDiv2 = FETCH_CYC_DIV2;

  if (RESET_MIN_CYCLES <= CLK_STABLE_PERIODS || ADDR_W < 8) begin : g_bad_param
    $error("reset length or address width too small");
  end

  logic resetActive;
  logic resetPinLevel;
  logic resetPrev;
  logic relEdge;
  logic adenSync;
  logic halfSync;
  logic float0Sync;
  logic float1Sync;
  logic uziSync;
  logic adenLatch;
  logic div2Latch;
  logic float0Latch;
  logic float1Latch;
  logic uziLatch;
  logic floatNow;
  rss_state_e state;
  rss_state_e next_state;
  logic [4:0] seqCnt;
  logic [4:0] fetchTarget;
  logic [CNT_W-1:0] resetLen;
  logic shortReset;
  logic umemDa;
  logic lmemDa;
  logic [3:0] umemBase;
  logic apbWrite;
  logic apbSetup;
  logic addrHit;

  rss_sync3 #(.INIT(1'b0)) u_sync_reset (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(resetInLow_b),
    .level(resetPinLevel)
  );
  rss_sync3 #(.INIT(1'b1)) u_sync_addr_enable_strap (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(addrEnableStrap),
    .level(adenSync)
  );
  rss_sync3 #(.INIT(1'b1)) u_sync_half (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(halfClockStrap),
    .level(halfSync)
  );
  rss_sync3 #(.INIT(1'b1)) u_sync_float0 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(floatTestStrap0),
    .level(float0Sync)
  );
  rss_sync3 #(.INIT(1'b1)) u_sync_float1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(floatTestStrap1),
    .level(float1Sync)
  );
  rss_sync3 #(.INIT(1'b1)) u_sync_uzi (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(upperZeroFlag),
    .level(uziSync)
  );

  assign resetActive = ~resetPinLevel;
  assign relEdge = resetPrev & ~resetActive;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetPrev <= 1'b1;
    end else begin
      resetPrev <= resetActive;
    end
  end

  // straps taken at release; address strap one clock later
  rss_strap_hold #(.INIT(1'b1)) u_hold_half (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .capture(relEdge),
    .strapIn(halfSync),
    .held(div2Latch)
  );
  rss_strap_hold #(.INIT(1'b1)) u_hold_float0 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .capture(relEdge),
    .strapIn(float0Sync),
    .held(float0Latch)
  );
  rss_strap_hold #(.INIT(1'b1)) u_hold_float1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .capture(relEdge),
    .strapIn(float1Sync),
    .held(float1Latch)
  );
  rss_strap_hold #(.INIT(1'b1)) u_hold_uzi (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .capture(relEdge),
    .strapIn(uziSync),
    .held(uziLatch)
  );
  rss_strap_hold #(.INIT(1'b1)) u_hold_addr_enable_strap (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .capture(state == ST_SAMPLE && !resetActive),
    .strapIn(adenSync),
    .held(adenLatch)
  );

  // float mode ends as soon as a new reset starts
  assign floatNow = ~float0Latch & ~float1Latch & ~resetActive;
  // half-clock strap low selects divide by two
  assign fetchTarget = div2Latch ? 5'(FETCH_CYC_DIV1) : 5'(FETCH_CYC_DIV2);

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (relEdge) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: next_state = ST_WAIT;
      ST_WAIT: begin
        if (seqCnt == fetchTarget - 5'h01) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_RESET;
    endcase
    if (resetActive) begin
      next_state = ST_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seqCnt <= 5'h00;
    end else if (relEdge) begin
      seqCnt <= 5'h01;
    end else if (state == ST_SAMPLE || state == ST_WAIT) begin
      seqCnt <= seqCnt + 5'h01;
    end
  end

  // first fetch pulse at the boot vector
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchStart <= 1'b0;
      fetchAddr <= BOOT_VECTOR;
      coreReset <= 1'b1;
    end else begin
      fetchStart <= state == ST_WAIT && next_state == ST_RUN;
      fetchAddr <= BOOT_VECTOR;
      coreReset <= next_state != ST_RUN;
    end
  end

  // reset length check, depends on the source holding reset long enough
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetLen <= '0;
    end else if (!resetActive) begin
      resetLen <= '0;
    end else if (resetLen != CNT_W'(RESET_MIN_CYCLES)) begin
      resetLen <= resetLen + CNT_W'(1);
    end
  end

  // sticky flag; a new short release wins over a software clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shortReset <= 1'b0;
    end else if (relEdge && resetLen < CNT_W'(RESET_MIN_CYCLES)) begin
      shortReset <= 1'b1;
    end else if (apbWrite && paddr[7:0] == OFS_STATUS && pwdata[ST_SHORT_BIT]) begin
      shortReset <= 1'b0;
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign addrHit = paddr[7:0] == OFS_UMEM_CFG || paddr[7:0] == OFS_LMEM_CFG ||
                   paddr[7:0] == OFS_STATUS;
  assign pslverr = psel & penable & ~addrHit;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      umemDa <= 1'b0;
      umemBase <= UMEM_BASE_RST;
      lmemDa <= 1'b0;
    end else if (resetActive) begin
      umemDa <= 1'b0;
      umemBase <= UMEM_BASE_RST;
      lmemDa <= 1'b0;
    end else if (apbWrite && paddr[7:0] == OFS_UMEM_CFG) begin
      umemDa <= pwdata[DA_BIT];
      umemBase <= pwdata[UMEM_BASE_LSB +: 4];
    end else if (apbWrite && paddr[7:0] == OFS_LMEM_CFG) begin
      lmemDa <= pwdata[DA_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (apbSetup) begin
      prdata <= 32'h00000000;
      case (paddr[7:0])
        OFS_UMEM_CFG: begin
          prdata[DA_BIT] <= umemDa;
          prdata[UMEM_BASE_LSB +: 4] <= umemBase;
        end
        OFS_LMEM_CFG: prdata[DA_BIT] <= lmemDa;
        OFS_STATUS: begin
          prdata[ST_ADDR_ENABLE_STRAP_BIT] <= adenLatch;
          prdata[ST_DIV2_BIT] <= ~div2Latch;
          prdata[ST_FLOAT_BIT] <= floatNow;
          prdata[ST_CLKTEST_BIT] <= ~uziLatch;
          prdata[ST_RUN_BIT] <= state == ST_RUN;
          prdata[ST_SHORT_BIT] <= shortReset;
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // mode, bus and pin controls; oe_b high floats the pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      upperMemSelect_b <= 1'b1;
      addrOnMuxUpper <= 1'b1;
      addrOnMuxLower <= 1'b1;
      clkDivBy2 <= 1'b0;
      pllEnable <= 1'b1;
      clockTestMode <= 1'b0;
      allPinsFloat <= 1'b0;
      refresh2Oe_b <= 1'b1;
      dmaStatusOe_b <= 1'b1;
      timer0Oe_b <= 1'b1;
      timer1Oe_b <= 1'b1;
      upperZeroOe_b <= 1'b1;
      upperSelectOe_b <= 1'b1;
      halfClockPullupEn <= 1'b1;
      floatStrap1PullupEn <= 1'b1;
      generalIoMode <= 1'b1;
    end else begin
      // window from base nibble up to the top of memory
      upperMemSelect_b <= ~(fetchStart ||
                            (cycleStart && state == ST_RUN && cycleAddr[19:16] >= umemBase &&
                             cycleAddr[19:16] <= UMEM_TOP_NIB)) || busHold;
      addrOnMuxUpper <= ~(adenLatch & umemDa);
      addrOnMuxLower <= ~(adenLatch & lmemDa);
      clkDivBy2 <= ~div2Latch;
      pllEnable <= div2Latch;
      clockTestMode <= ~uziLatch & ~resetActive;
      allPinsFloat <= floatNow;
      refresh2Oe_b <= resetActive | busHold | floatNow;
      dmaStatusOe_b <= resetActive | busHold | floatNow | adenLatch;
      timer0Oe_b <= resetActive | busHold | floatNow;
      timer1Oe_b <= resetActive | busHold | floatNow;
      upperZeroOe_b <= resetActive | floatNow | adenLatch;
      upperSelectOe_b <= resetActive | floatNow;
      halfClockPullupEn <= resetActive | adenLatch;
      floatStrap1PullupEn <= resetActive;
      generalIoMode <= adenLatch;
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  logic [4:0] sinceRel;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sinceRel <= 5'h00;
    end else if (relEdge) begin
      sinceRel <= 5'h01;
    end else if (sinceRel != 5'h1F) begin
      sinceRel <= sinceRel + 5'h01;
    end
  end

  sequence release_seq;
    relEdge ##1 !resetActive;
  endsequence

  reset_abort_a: assert property (resetActive |=> state == ST_RESET && coreReset)
    else $error("reset did not abort the sequence");
  fetch_delay_a: assert property (fetchStart |-> sinceRel == fetchTarget)
    else $error("first fetch at wrong distance from release");
  fetch_bound_a: assert property (release_seq |->
    ##[1:fetchCycDiv2] (fetchStart || resetActive))
    else $error("first fetch missing after release");
  boot_select_a: assert property (fetchStart && !busHold |=>
    !upperMemSelect_b && fetchAddr == BOOT_VECTOR)
    else $error("boot fetch outside upper window");
  addr_enable_strap_sample_a: assert property (release_seq |=> adenLatch == $past(adenSync))
    else $error("address strap not sampled one clock after release");
  addr_enable_strap_low_a: assert property (!adenLatch |=> addrOnMuxUpper && addrOnMuxLower)
    else $error("address dropped from bus with strap low");
  addr_enable_strap_da_a: assert property (adenLatch && umemDa |=> !addrOnMuxUpper)
    else $error("address disable bit ignored");
  float_enter_a: assert property (relEdge && !float0Sync && !float1Sync ##1 !resetActive
    |=> allPinsFloat)
    else $error("float mode not entered");
  float_pins_a: assert property (allPinsFloat |-> refresh2Oe_b && dmaStatusOe_b &&
    timer0Oe_b && timer1Oe_b && upperZeroOe_b && upperSelectOe_b)
    else $error("pin driven in float mode");
  hold_float_a: assert property ((resetActive || busHold) |=>
    timer0Oe_b && timer1Oe_b && dmaStatusOe_b && refresh2Oe_b)
    else $error("output driven in reset or hold");
  hold_select_a: assert property (busHold && !resetActive && !floatNow |=>
    !upperSelectOe_b && upperMemSelect_b)
    else $error("upper select pin not driven high in hold");
  clock_mode_a: assert property (clkDivBy2 == !pllEnable)
    else $error("pll not disabled in divide mode");
endmodule
`default_nettype wire

// [rss_board.sv]
// board model: external reset source and strap resistors around the sequencer
// assumes a free-running core_clk; the bench calls holdLow and releasePin
`timescale 1ns/1ns
`default_nettype none
module rss_board (
  input wire logic core_clk,
  input wire logic [4:0] strapSet,
  output logic resetInLow_b,
  output logic addrEnableStrap,
  output logic halfClockStrap,
  output logic floatTestStrap0,
  output logic floatTestStrap1,
  output logic upperZeroFlag
);
  logic toggle;
  int sinceRel;
  initial begin
    resetInLow_b = 1'b0;
    toggle = 1'b0;
    sinceRel = 0;
  end
  always @(posedge core_clk) begin
    toggle <= ~toggle;
    sinceRel <= !resetInLow_b ? 0 : (sinceRel < 63 ? sinceRel + 1 : sinceRel);
  end
  // resistor levels through reset and a settle time, then pins carry traffic
  always @* begin
    if (!resetInLow_b || sinceRel < 12) begin
      {addrEnableStrap, halfClockStrap, floatTestStrap0, floatTestStrap1, upperZeroFlag} =
        strapSet;
    end else begin
      {addrEnableStrap, halfClockStrap, floatTestStrap0, floatTestStrap1, upperZeroFlag} =
        {5{toggle}} ^ 5'h15;
    end
  end
  // hold the pin low n cycles with the clock running; n set by the caller
  task automatic holdLow(input int n);
    @(posedge core_clk);
    resetInLow_b <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic releasePin();
    resetInLow_b <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [rss_top_tb.sv]
// testbench for the reset sequencer: board model, apb master, sequence checks
// assumes rss_top with a shortened minimum reset count
`timescale 1ns/1ns
`default_nettype none
module rss_top_tb;
  import rss_pkg::*;
  localparam int MINC = 20;
  logic core_clk, rst_b, busHold, cycleStart, psel, penable, pwrite, pready, pslverr, err;
  logic [19:0] cycleAddr, fetchAddr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic coreReset, fetchStart, upperMemSelect_b, addrOnMuxUpper, addrOnMuxLower;
  logic clkDivBy2, pllEnable, clockTestMode, allPinsFloat, refresh2Oe_b, dmaStatusOe_b;
  logic timer0Oe_b, timer1Oe_b, upperZeroOe_b, upperSelectOe_b;
  logic halfClockPullupEn, floatStrap1PullupEn, generalIoMode;
  logic resetInLow_b, addrEnableStrap, halfClockStrap, floatTestStrap0, floatTestStrap1;
  logic upperZeroFlag;
  logic [4:0] strapSet;
  int n_mismatch, check_count, d1, d2, nFetch, nSeen;

  rss_board board_u (.core_clk(core_clk), .strapSet(strapSet), .resetInLow_b(resetInLow_b),
    .addrEnableStrap(addrEnableStrap), .halfClockStrap(halfClockStrap),
    .floatTestStrap0(floatTestStrap0), .floatTestStrap1(floatTestStrap1),
    .upperZeroFlag(upperZeroFlag));
  rss_top #(.RESET_MIN_CYCLES(MINC)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .resetInLow_b(resetInLow_b), .addrEnableStrap(addrEnableStrap),
    .halfClockStrap(halfClockStrap), .floatTestStrap0(floatTestStrap0),
    .floatTestStrap1(floatTestStrap1), .upperZeroFlag(upperZeroFlag), .busHold(busHold),
    .cycleStart(cycleStart), .cycleAddr(cycleAddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreReset(coreReset), .fetchStart(fetchStart),
    .fetchAddr(fetchAddr), .upperMemSelect_b(upperMemSelect_b),
    .addrOnMuxUpper(addrOnMuxUpper), .addrOnMuxLower(addrOnMuxLower),
    .clkDivBy2(clkDivBy2), .pllEnable(pllEnable), .clockTestMode(clockTestMode),
    .allPinsFloat(allPinsFloat), .refresh2Oe_b(refresh2Oe_b),
    .dmaStatusOe_b(dmaStatusOe_b), .timer0Oe_b(timer0Oe_b), .timer1Oe_b(timer1Oe_b),
    .upperZeroOe_b(upperZeroOe_b), .upperSelectOe_b(upperSelectOe_b),
    .halfClockPullupEn(halfClockPullupEn), .floatStrap1PullupEn(floatStrap1PullupEn),
    .generalIoMode(generalIoMode));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (fetchStart === 1'b1) nFetch++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic runSeq(input logic [4:0] s, input int hold, input bit want, output int dly);
    @(posedge core_clk);
    strapSet <= s;
    board_u.holdLow(hold);
    chk(coreReset, 1'b1);
    chk({timer0Oe_b, timer1Oe_b}, 2'b11);
    chk(dmaStatusOe_b, 1'b1);
    chk(floatStrap1PullupEn, 1'b1);
    board_u.releasePin();
    dly = 0;
    while (fetchStart !== 1'b1 && dly < 100) begin
      @(posedge core_clk);
      dly++;
    end
    if (dly >= 100 && want) begin
      n_mismatch++;
      summarize();
    end
    @(posedge core_clk);
    if (want) chk(upperMemSelect_b, 1'b0);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic busCycle(input logic [19:0] a, input logic exp);
    @(posedge core_clk);
    cycleStart <= 1'b1;
    cycleAddr <= a;
    @(posedge core_clk);
    cycleStart <= 1'b0;
    @(posedge core_clk);
    chk(upperMemSelect_b, exp);
  endtask

  initial begin
    rst_b = 1'b0;
    busHold = 1'b0;
    cycleStart = 1'b0;
    cycleAddr = 20'h00000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    strapSet = 5'h1F;
    n_mismatch = 0;
    check_count = 0;
    nFetch = 0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    runSeq(5'h1F, MINC + 10, 1'b1, d1);
    chk(fetchAddr, BOOT_VECTOR);
    chk({clkDivBy2, pllEnable}, 2'b01);
    chk({allPinsFloat, clockTestMode}, 2'b00);
    chk({generalIoMode, halfClockPullupEn}, 2'b11);
    chk(floatStrap1PullupEn, 1'b0);
    chk({timer0Oe_b, timer1Oe_b, dmaStatusOe_b, refresh2Oe_b}, 4'h2);
    chk(upperZeroOe_b, 1'b1);
    apb(1'b0, OFS_UMEM_CFG, 32'h0);
    chk(rd, 32'h000000F0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h00000011);
    busHold <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({timer0Oe_b, timer1Oe_b, dmaStatusOe_b}, 3'h7);
    chk(refresh2Oe_b, 1'b1);
    chk(upperSelectOe_b, 1'b0);
    busCycle(20'hF1234, 1'b1);
    busHold <= 1'b0;
    busCycle(20'hFFFFF, 1'b0);
    busCycle(20'hEFFFF, 1'b1);
    chk({addrOnMuxUpper, addrOnMuxLower}, 2'b11);
    apb(1'b1, OFS_UMEM_CFG, 32'h000000F1);
    apb(1'b1, OFS_LMEM_CFG, 32'h00000001);
    repeat (2) @(posedge core_clk);
    chk({addrOnMuxUpper, addrOnMuxLower}, 2'b00);
    apb(1'b0, OFS_UMEM_CFG, 32'h0);
    chk(rd, 32'h000000F1);
    apb(1'b0, OFS_LMEM_CFG, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    // abort in the middle of the start-up sequence
    board_u.holdLow(MINC + 10);
    board_u.releasePin();
    repeat (2) @(posedge core_clk);
    nSeen = nFetch;
    board_u.holdLow(MINC + 10);
    chk(coreReset, 1'b1);
    chk(nFetch, nSeen);
    runSeq(5'h17, MINC + 10, 1'b1, d2);
    chk({clkDivBy2, pllEnable}, 2'b10);
    chk(d2 - d1, 6);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h00000013);
    runSeq(5'h0F, MINC + 10, 1'b1, d1);
    chk(generalIoMode, 1'b0);
    chk({dmaStatusOe_b, upperZeroOe_b, halfClockPullupEn}, 3'b000);
    apb(1'b1, OFS_UMEM_CFG, 32'h000000F1);
    repeat (2) @(posedge core_clk);
    chk(addrOnMuxUpper, 1'b1);
    runSeq(5'h19, MINC + 10, 1'b0, d1);
    chk(allPinsFloat, 1'b1);
    chk({refresh2Oe_b, dmaStatusOe_b, timer0Oe_b, timer1Oe_b}, 4'hF);
    chk({upperZeroOe_b, upperSelectOe_b}, 2'b11);
    runSeq(5'h1A, MINC + 10, 1'b1, d1);
    chk({allPinsFloat, clockTestMode}, 2'b01);
    runSeq(5'h1F, 8, 1'b1, d1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_SHORT_BIT], 1'b1);
    apb(1'b1, OFS_STATUS, 32'h00000020);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_SHORT_BIT], 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
